// file: verilog/touch_adc_clock_irq_regs.sv
// Functional notes
// - Bit 3 at 0xff13 switches the converter clock on or off, reset off.
// - Bits 2..0 at 0xff13: 011 gives /8, 010 /4, top bit set /16.
// - Bit 3 at 0xff16 switches the touch controller clock, reset off.
// - Bits 2..0 at 0xff16: 010 gives /4, 001 gives /2, reset 000.
// - Bit 7 at 0xff26 enables the conversion-done interrupt, reset zero.
// - Bit 6 at 0xff26 enables the pen-down interrupt.
// - Bit 5 at 0xff26 enables the data update interrupt, reset zero.
// - Bit 7 at 0xff2a flags conversion done; writing one clears it.
// - Bit 6 at 0xff2a flags pen-down; writing one clears, zero does nothing.
// - Bit 5 at 0xff2a flags data update; writing one clears it.
// - Bits 7..6 and 5..4 at 0xff22 give interrupt levels 0 to 3.
// - A detected pen-down sets its flag and interrupts when enabled.
// - A coordinate data update sets its flag.
// - A request reaches the processor only while flag and enable are set.
`timescale 1ns/10ps
`default_nettype none
`include "touch_adc_params.svh"

module touch_adc_clock_irq_regs
  import touch_adc_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input  wire logic              aclk,             // Clock, 250 MHz
  input  wire logic              aresetn,          // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,           // Write address
  input  wire logic [2:0]        awprot,           // Write protection, unused
  input  wire logic              awvalid,          // Write address valid
  output var  logic              awready,          // Write address ready
  input  wire logic [31:0]       wdata,            // Write data
  input  wire logic [3:0]        wstrb,            // Write byte strobes
  input  wire logic              wvalid,           // Write data valid
  output var  logic              wready,           // Write data ready
  output var  logic [1:0]        bresp,            // Write response
  output var  logic              bvalid,           // Write response valid
  input  wire logic              bready,           // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,           // Read address
  input  wire logic [2:0]        arprot,           // Read protection, unused
  input  wire logic              arvalid,          // Read address valid
  output var  logic              arready,          // Read address ready
  output var  logic [31:0]       rdata,            // Read data
  output var  logic [1:0]        rresp,            // Read response
  output var  logic              rvalid,           // Read data valid
  input  wire logic              rready,           // Read data ready
  input  wire irq_events_t       events,           // One-cycle event pulses
  output var  logic              adc_clock_tick,   // Converter clock enable pulse
  output var  logic              touch_clock_tick, // Touch controller clock enable pulse
  output var  logic [1:0]        adc_irq_level,    // Converter interrupt level
  output var  logic [1:0]        touch_irq_level,  // Touch interrupt level
  output var  logic              adc_done_irq,     // Conversion-done request
  output var  logic              pen_down_irq,     // Pen-down request
  output var  logic              data_update_irq,  // Data update request
  output var  logic              irq               // Any enabled request
);

  if (ADDR_W < 18)
  begin : g_addr_check
    $error("ADDR_W must reach the highest register index");
  end

  ////////////////////////////////////////////////////////////////////////////
  core_state_t s;
  core_state_t next_s;
  logic [7:0]  event_bits;
  logic [7:0]  clear_bits;
  logic        write_fire;
  logic [8:0]  read_word;
  logic [8:0]  write_word;

  function automatic logic [8:0] read_reg(input logic [15:0] idx, input reg_file_t r);
    case (idx)
      `IDX_ADC_CLOCK_SELECT:   read_reg = {1'b1, r.adc_clock_select};
      `IDX_TOUCH_CLOCK_SELECT: read_reg = {1'b1, r.touch_clock_select};
      `IDX_IRQ_PRIORITY:       read_reg = {1'b1, r.priority_levels};
      `IDX_IRQ_ENABLES:        read_reg = {1'b1, r.irq_enables};
      `IDX_IRQ_FLAGS:          read_reg = {1'b1, r.irq_flags};
      `IDX_IRQ_STATUS:         read_reg = {1'b1, r.irq_flags};
      `IDX_IRQ_CLEAR:          read_reg = {1'b1, `RESET_BYTE};
      default:                 read_reg = {1'b0, `RESET_BYTE};
    endcase
  endfunction : read_reg

  always_comb
  begin
    event_bits                   = `RESET_BYTE;
    event_bits[`POS_ADC_DONE]    = events.adc_done;
    event_bits[`POS_PEN_DOWN]    = events.pen_down;
    event_bits[`POS_DATA_UPDATE] = events.data_update;
  end

  // Address and data are latched independently; the write is done one cycle
  // after both are held, which keeps the decode off the bus inputs.
  assign write_fire = s.axi.aw_seen && s.axi.w_seen && !s.axi.bvalid;
  assign read_word  = read_reg(araddr[17:2], s.regs);
  assign write_word = read_reg(s.axi.aw_index, s.regs);

  always_comb
  begin
    next_s     = s;
    clear_bits = `RESET_BYTE;
    if (awvalid && s.axi.awready)
    begin
      next_s.axi.aw_seen  = 1'b1;
      next_s.axi.aw_index = awaddr[17:2];
    end
    if (wvalid && s.axi.wready)
    begin
      next_s.axi.w_seen = 1'b1;
      next_s.axi.wbyte  = wdata[7:0];
      next_s.axi.wlane  = wstrb[0];
    end
    if (s.axi.bvalid && bready)
      next_s.axi.bvalid = 1'b0;
    if (write_fire)
    begin
      next_s.axi.aw_seen = 1'b0;
      next_s.axi.w_seen  = 1'b0;
      next_s.axi.bvalid  = 1'b1;
      next_s.axi.bresp   = write_word[8] ? `RESP_OKAY : `RESP_SLVERR;
      if (s.axi.wlane)
      begin
        case (s.axi.aw_index)
          `IDX_ADC_CLOCK_SELECT:   next_s.regs.adc_clock_select   = s.axi.wbyte & `MASK_CLOCK_SELECT;
          `IDX_TOUCH_CLOCK_SELECT: next_s.regs.touch_clock_select = s.axi.wbyte & `MASK_CLOCK_SELECT;
          `IDX_IRQ_PRIORITY:       next_s.regs.priority_levels    = s.axi.wbyte & `MASK_PRIORITY;
          `IDX_IRQ_ENABLES:        next_s.regs.irq_enables        = s.axi.wbyte & `MASK_IRQ;
          `IDX_IRQ_FLAGS:          clear_bits                     = s.axi.wbyte & `MASK_IRQ;
          `IDX_IRQ_CLEAR:          clear_bits                     = s.axi.wbyte & `MASK_IRQ;
          default:                 clear_bits                     = `RESET_BYTE;
        endcase
      end
    end
    // An event in the cycle of its clear still leaves the flag set.
    next_s.regs.irq_flags = ((s.regs.irq_flags & ~clear_bits) | event_bits) & `MASK_IRQ;
    if (s.axi.rvalid && rready)
      next_s.axi.rvalid = 1'b0;
    if (arvalid && s.axi.arready)
    begin
      next_s.axi.rvalid = 1'b1;
      next_s.axi.rdata  = {24'h000000, read_word[7:0]};
      next_s.axi.rresp  = read_word[8] ? `RESP_OKAY : `RESP_SLVERR;
    end
    next_s.axi.awready = !next_s.axi.aw_seen && !next_s.axi.bvalid;
    next_s.axi.wready  = !next_s.axi.w_seen && !next_s.axi.bvalid;
    next_s.axi.arready = !next_s.axi.rvalid;
    next_s.adc_done_irq    = next_s.regs.irq_flags[`POS_ADC_DONE] && next_s.regs.irq_enables[`POS_ADC_DONE];
    next_s.pen_down_irq    = next_s.regs.irq_flags[`POS_PEN_DOWN] && next_s.regs.irq_enables[`POS_PEN_DOWN];
    next_s.data_update_irq = next_s.regs.irq_flags[`POS_DATA_UPDATE]
                             && next_s.regs.irq_enables[`POS_DATA_UPDATE];
    next_s.irq             = |(next_s.regs.irq_flags & next_s.regs.irq_enables);
    next_s.adc_irq_level   = next_s.regs.priority_levels[`POS_ADC_LEVEL +: 2];
    next_s.touch_irq_level = next_s.regs.priority_levels[`POS_TOUCH_LEVEL +: 2];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign awready         = s.axi.awready;
  assign wready          = s.axi.wready;
  assign bvalid          = s.axi.bvalid;
  assign bresp           = s.axi.bresp;
  assign arready         = s.axi.arready;
  assign rvalid          = s.axi.rvalid;
  assign rresp           = s.axi.rresp;
  assign rdata           = s.axi.rdata;
  assign adc_done_irq    = s.adc_done_irq;
  assign pen_down_irq    = s.pen_down_irq;
  assign data_update_irq = s.data_update_irq;
  assign irq             = s.irq;
  assign adc_irq_level   = s.adc_irq_level;
  assign touch_irq_level = s.touch_irq_level;

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] div_gate;
  logic [2:0] div_select [2];
  logic [1:0] div_tick;

  assign div_gate[0]   = s.regs.adc_clock_select[`POS_CLOCK_GATE];
  assign div_gate[1]   = s.regs.touch_clock_select[`POS_CLOCK_GATE];
  assign div_select[0] = s.regs.adc_clock_select[2:0];
  assign div_select[1] = s.regs.touch_clock_select[2:0];

  for (genvar i = 0; i < 2; i++)
  begin : g_prescaler
    clock_prescaler u_prescaler (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .gate         (div_gate[i]),
      .ratio_select (div_select[i]),
      .tick         (div_tick[i])
    );
  end

  assign adc_clock_tick   = div_tick[0];
  assign touch_clock_tick = div_tick[1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_adc_gate_off: assert property (
    !s.regs.adc_clock_select[`POS_CLOCK_GATE] |=> !adc_clock_tick)
    else $error("converter clock ticks while gated off");

  chk_touch_gate_off: assert property (
    !s.regs.touch_clock_select[`POS_CLOCK_GATE] |=> !touch_clock_tick)
    else $error("touch clock ticks while gated off");

  chk_enable_write: assert property (
    write_fire && s.axi.wlane && s.axi.aw_index == `IDX_IRQ_ENABLES
    |=> s.regs.irq_enables == ($past(s.axi.wbyte) & `MASK_IRQ))
    else $error("enable register did not take written value");

  chk_flag_clear: assert property (
    1'b1 |=> (s.regs.irq_flags & $past(clear_bits & ~event_bits)) == 8'h00)
    else $error("factor flag survived a clear");

  chk_flag_hold: assert property (
    1'b1 |=> (($past(s.regs.irq_flags) & ~$past(clear_bits)) & ~s.regs.irq_flags) == 8'h00)
    else $error("factor flag dropped without a clear");

  chk_event_sets: assert property (
    events.pen_down || events.data_update || events.adc_done
    |=> ((s.regs.irq_flags & $past(event_bits)) == $past(event_bits)))
    else $error("event did not set its factor flag");

  chk_pen_request: assert property (
    events.pen_down && s.regs.irq_enables[`POS_PEN_DOWN] && !(write_fire && s.axi.aw_index == `IDX_IRQ_ENABLES)
    |=> pen_down_irq && irq)
    else $error("pen-down did not raise its request");

  chk_request_gate: assert property (
    irq == |(s.regs.irq_flags & s.regs.irq_enables) && adc_done_irq == (s.regs.irq_flags[7] && s.regs.irq_enables[7]))
    else $error("request does not follow flag and enable");

  chk_level_write: assert property (
    write_fire && s.axi.wlane && s.axi.aw_index == `IDX_IRQ_PRIORITY
    |=> touch_irq_level == $past(s.axi.wbyte[5:4]) && adc_irq_level == $past(s.axi.wbyte[7:6]))
    else $error("priority levels did not take written value");

  chk_unused_zero: assert property (
    (!rvalid || rdata[31:8] == 24'h000000) && (s.regs.adc_clock_select & ~`MASK_CLOCK_SELECT) == 8'h00)
    else $error("unused bits are not zero");

  chk_write_answer: assert property (
    write_fire |=> bvalid)
    else $error("write response missing");

  chk_read_answer: assert property (
    arvalid && arready |=> rvalid)
    else $error("read data missing");

  chk_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before it was taken");

  chk_write_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before it was taken");

  chk_ready_off: assert property (
    (!bvalid || (!awready && !wready)) && (!rvalid || !arready))
    else $error("new request accepted while an answer is pending");

  chk_flag_read: assert property (
    arvalid && arready && araddr[17:2] == `IDX_IRQ_FLAGS
    |=> rdata == {24'h000000, $past(s.regs.irq_flags)} && rresp == `RESP_OKAY)
    else $error("factor flags read back wrong");

  chk_status_copy: assert property (
    arvalid && arready && araddr[17:2] == `IDX_IRQ_STATUS
    |=> rdata == {24'h000000, $past(s.regs.irq_flags)} && rresp == `RESP_OKAY)
    else $error("status copy differs from factor flags");

  chk_clear_read: assert property (
    arvalid && arready && araddr[17:2] == `IDX_IRQ_CLEAR
    |=> rdata == 32'h00000000 && rresp == `RESP_OKAY)
    else $error("clear register did not read as zero");

  // A write whose low lane strobe is off must leave every register alone.
  chk_lane_off: assert property (
    write_fire && !s.axi.wlane
    |=> $stable(s.regs.adc_clock_select) && $stable(s.regs.touch_clock_select)
        && $stable(s.regs.priority_levels) && $stable(s.regs.irq_enables)
        && ($past(s.regs.irq_flags) & ~s.regs.irq_flags) == 8'h00)
    else $error("write without its lane strobe changed a register");

  chk_reset_clear: assert property (
    $rose(aresetn) |-> s.regs == '0 && !irq && !adc_clock_tick && !touch_clock_tick)
    else $error("registers not cleared by reset");

  cov_pen_irq:    cover property (events.pen_down ##1 pen_down_irq);
  cov_adc_div16:  cover property (adc_clock_tick && s.regs.adc_clock_select[2]);
  cov_flag_clear: cover property (write_fire && s.axi.aw_index == `IDX_IRQ_FLAGS ##1 !irq);
  cov_read:       cover property (rvalid && rready && rresp == `RESP_OKAY);
  cov_lane_off:   cover property (write_fire && !s.axi.wlane);

endmodule : touch_adc_clock_irq_regs
`default_nettype wire

// file: verilog/touch_adc_params.svh
`ifndef TOUCH_ADC_PARAMS_SVH
`define TOUCH_ADC_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_ADC_CLOCK_SELECT   16'hff13
`define IDX_TOUCH_CLOCK_SELECT 16'hff16
`define IDX_IRQ_PRIORITY       16'hff22
`define IDX_IRQ_ENABLES        16'hff26
`define IDX_IRQ_FLAGS          16'hff2a
`define IDX_IRQ_STATUS         16'hff30
`define IDX_IRQ_CLEAR          16'hff31

// Field positions.
`define POS_CLOCK_GATE         3
`define POS_ADC_DONE           7
`define POS_PEN_DOWN           6
`define POS_DATA_UPDATE        5
`define POS_ADC_LEVEL          6
`define POS_TOUCH_LEVEL        4

// Implemented bits of each register; all others read as zero.
`define MASK_CLOCK_SELECT      8'h0f
`define MASK_PRIORITY          8'hf0
`define MASK_IRQ               8'he0
`define RESET_BYTE             8'h00

// Divider masks: a tick falls where the masked count bits are all ones.
`define DIV_MASK_16            4'hf
`define DIV_MASK_8             4'h7
`define DIV_MASK_4             4'h3
`define DIV_MASK_2             4'h1
`define DIV_MASK_1             4'h0

`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// file: verilog/touch_adc_pkg.sv
package touch_adc_pkg;

  typedef struct packed {
    logic adc_done;
    logic pen_down;
    logic data_update;
  } irq_events_t;

  typedef struct packed {
    logic [3:0] count;
    logic       tick;
  } prescaler_state_t;

  typedef struct packed {
    logic [7:0] adc_clock_select;
    logic [7:0] touch_clock_select;
    logic [7:0] priority_levels;
    logic [7:0] irq_enables;
    logic [7:0] irq_flags;
  } reg_file_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_seen;
    logic        w_seen;
    logic [15:0] aw_index;
    logic [7:0]  wbyte;
    logic        wlane;
  } axi_state_t;

  typedef struct packed {
    reg_file_t  regs;
    axi_state_t axi;
    logic       adc_done_irq;
    logic       pen_down_irq;
    logic       data_update_irq;
    logic       irq;
    logic [1:0] adc_irq_level;
    logic [1:0] touch_irq_level;
  } core_state_t;

endpackage : touch_adc_pkg

// file: verilog/clock_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_adc_params.svh"

module clock_prescaler
  import touch_adc_pkg::*;
(
  input  wire logic       aclk,          // System and oscillator clock
  input  wire logic       aresetn,       // Synchronous reset, active low
  input  wire logic       gate,          // Clock supply on
  input  wire logic [2:0] ratio_select,  // Division ratio code
  output var  logic       tick           // One-cycle enable at the divided rate
);

  prescaler_state_t s;
  prescaler_state_t next_s;

  function automatic logic [3:0] ratio_mask(input logic [2:0] sel);
    if (sel[2])
      ratio_mask = `DIV_MASK_16;
    else if (sel == 3'h3)
      ratio_mask = `DIV_MASK_8;
    else if (sel == 3'h2)
      ratio_mask = `DIV_MASK_4;
    else if (sel == 3'h1)
      ratio_mask = `DIV_MASK_2;
    else
      ratio_mask = `DIV_MASK_1;
  endfunction : ratio_mask

  // The counter runs free so that a ratio change takes effect at once, at
  // the cost of one irregular first period after the change.
  always_comb
  begin
    next_s       = s;
    next_s.count = s.count + 4'h1;
    next_s.tick  = gate && ((s.count & ratio_mask(ratio_select)) == ratio_mask(ratio_select));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] since;
  logic       steady;
  logic [2:0] sel_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      since  <= 5'h00;
      steady <= 1'b0;
      sel_q  <= 3'h0;
    end
    else
    begin
      sel_q  <= ratio_select;
      since  <= s.tick ? 5'h00 : ((since == 5'h1f) ? since : since + 5'h01);
      steady <= (s.tick || steady) && gate && (ratio_select == sel_q);
    end
  end

  chk_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
    s.tick && steady |-> since == {1'b0, ratio_mask(sel_q)})
    else $error("prescaler tick period does not match ratio");

endmodule : clock_prescaler
`default_nettype wire

// file: testbench/touch_adc_clock_irq_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "touch_adc_params.svh"

module touch_adc_clock_irq_regs_tb
  import touch_adc_pkg::*;
();
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [17:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  irq_events_t events;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, adc_irq_level, touch_irq_level;
  logic        adc_clock_tick, touch_clock_tick, adc_done_irq, pen_down_irq, data_update_irq, irq;
  int          failures, checked, cycles;
  logic [7:0]  m [0:7];

  touch_adc_clock_irq_regs touch_adc_clock_irq_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .events(events), .adc_clock_tick(adc_clock_tick),
    .touch_clock_tick(touch_clock_tick), .adc_irq_level(adc_irq_level), .touch_irq_level(touch_irq_level),
    .adc_done_irq(adc_done_irq), .pen_down_irq(pen_down_irq), .data_update_irq(data_update_irq), .irq(irq)
  );

  always #2 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // A hung handshake would stall the run, so a cycle ceiling ends it as a failure.
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////////
  // Model slots: 0..4 the five control bytes, 5 status copy, 6 clear, 7 an unmapped word.
  function automatic logic [15:0] idx_of(input int k);
    case (k)
      0: return `IDX_ADC_CLOCK_SELECT;
      1: return `IDX_TOUCH_CLOCK_SELECT;
      2: return `IDX_IRQ_PRIORITY;
      3: return `IDX_IRQ_ENABLES;
      4: return `IDX_IRQ_FLAGS;
      5: return `IDX_IRQ_STATUS;
      6: return `IDX_IRQ_CLEAR;
      default: return 16'hff14;
    endcase
  endfunction : idx_of

  function automatic logic [7:0] model_read(input int k);
    if (k == 5)
      return m[4];
    if (k >= 6)
      return 8'h00;
    return m[k];
  endfunction : model_read

  task automatic model_write(input int k, input logic [7:0] d);
    case (k)
      0, 1: m[k] = d & `MASK_CLOCK_SELECT;
      2: m[k] = d & `MASK_PRIORITY;
      3: m[k] = d & `MASK_IRQ;
      4, 6: m[4] = m[4] & ~d;
      default: ;
    endcase
  endtask : model_write

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input int k, input logic [7:0] d, input logic lane = 1'b1);
    logic [1:0] resp;
    resp = 2'bxx;
    @(posedge aclk);
    awaddr  <= {idx_of(k), 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= {3'($urandom), lane};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        resp = bresp;
        bready <= 1'b0;
      end
    end while (awvalid || wvalid || bready);
    check("bresp", resp, (k == 7) ? `RESP_SLVERR : `RESP_OKAY);
    if (lane)
      model_write(k, d);
  endtask : axi_write

  task automatic axi_read(input int k);
    logic [31:0] data;
    logic [1:0]  resp;
    data = 'x;
    resp = 2'bxx;
    @(posedge aclk);
    araddr  <= {idx_of(k), 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end while (arvalid || rready);
    check("rdata", data, {24'h000000, model_read(k)});
    check("rresp", resp, (k == 7) ? `RESP_SLVERR : `RESP_OKAY);
  endtask : axi_read

  task automatic check_outputs;
    @(posedge aclk);
    check("adc_irq_level", adc_irq_level, m[2][7:6]);
    check("touch_irq_level", touch_irq_level, m[2][5:4]);
    check("adc_done_irq", adc_done_irq, m[3][7] & m[4][7]);
    check("pen_down_irq", pen_down_irq, m[3][6] & m[4][6]);
    check("data_update_irq", data_update_irq, m[3][5] & m[4][5]);
    check("irq", irq, |(m[3] & m[4]));
  endtask : check_outputs

  // Ticks in a 64-cycle window; a free counter makes this exact for every ratio.
  function automatic int ticks64(input logic [7:0] v);
    if (!v[3])
      return 0;
    if (v[2])
      return 4;
    case (v[1:0])
      2'd3: return 8;
      2'd2: return 16;
      2'd1: return 32;
      default: return 64;
    endcase
  endfunction : ticks64

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int          na, nt;
    logic [7:0]  a, t;
    logic [2:0]  ev;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
    events = '0;
    failures = 0;
    checked = 0;
    cycles = 0;
    for (int k = 0; k < 8; k++)
      m[k] = `RESET_BYTE;
    void'($urandom(32'h3aff7908));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check_outputs();
    for (int k = 0; k < 8; k++)
      axi_read(k);
    // Every slot is written with all ones and then random bytes, read-only and unmapped ones too.
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 8; k++)
      begin
        axi_write(k, (p == 0) ? 8'hff : 8'($urandom));
        check_outputs();
        axi_read(k);
      end
    // A write without its low lane strobe is answered but changes nothing.
    axi_write(2, ~m[2], 1'b0);
    check_outputs();
    axi_read(2);
    for (int i = 0; i < 9; i++)
    begin
      a = (i < 8) ? {5'b00001, 3'(i)} : 8'($urandom) & 8'hf7;
      t = (i < 8) ? {5'b00001, 3'(7 - i)} : 8'($urandom) & 8'hf7;
      axi_write(0, a);
      axi_write(1, t);
      repeat (4) @(posedge aclk);
      na = 0;
      nt = 0;
      repeat (64)
      begin
        @(posedge aclk);
        na += int'(adc_clock_tick);
        nt += int'(touch_clock_tick);
      end
      check("adc ticks", na, ticks64(m[0]));
      check("touch ticks", nt, ticks64(m[1]));
    end
    // Events land on random enable patterns; clears alternate between the two clear paths.
    for (int i = 0; i < 10; i++)
    begin
      axi_write(3, 8'($urandom));
      ev = 3'($urandom);
      @(posedge aclk);
      events <= irq_events_t'(ev);
      @(posedge aclk);
      events <= '0;
      m[4] = m[4] | {ev, 5'b00000};
      check_outputs();
      axi_read(4);
      axi_read(5);
      axi_write((i % 2) ? 6 : 4, 8'($urandom));
      check_outputs();
      axi_read(4);
    end
    // A reset in mid-run must return every register and request to zero.
    axi_write(2, 8'hff);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 8; k++)
      m[k] = `RESET_BYTE;
    check_outputs();
    for (int k = 0; k < 5; k++)
      axi_read(k);
    give_verdict();
  end
endmodule : touch_adc_clock_irq_regs_tb
`default_nettype wire
